// *** src/eba_arbiter.sv ***
// external port bus request/grant arbiter and shared dma bus arbiter
// assumes inputs other than ext_bus_request_n synchronous to clk; pins resolved outside from enables
`timescale 1ns/10ps
module eba_arbiter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic dev_reset_n,
    input wire logic ext_bus_request_n,
    input wire logic exclusive_core,
    input wire logic bus_8bit,
    input wire eba_pkg::eba_acc_s core_acc,
    input wire eba_pkg::eba_acc_s periph_acc,
    input wire logic [eba_pkg::DATA_W-1:0] data_in,
    input wire logic [eba_pkg::NUM_CH-1:0] dma_start,
    input wire eba_pkg::eba_desc_s dma_desc,
    input wire eba_pkg::eba_desc_s dma_next_desc,
    output logic ext_bus_grant_n,
    output logic grant_hang_n,
    output logic core_stall,
    output logic acc_done,
    output logic [eba_pkg::DATA_W-1:0] rdata,
    output eba_pkg::eba_pins_s pins_out,
    output logic pins_oe,
    output logic data_oe,
    output logic [eba_pkg::NUM_CH-1:0] dma_grant,
    output logic [eba_pkg::CH_W-1:0] dma_grant_ch,
    output logic [eba_pkg::NUM_CH-1:0] dma_done,
    output logic [eba_pkg::ADDR_W-1:0] dma_addr
);
    eba_pkg::eba_arb_e state_r;
    eba_pkg::eba_arb_e state_nxt;
    logic [1:0] wait_r;
    logic req_sync1_r;
    logic req_sync2_r;
    logic pair_lock_r;
    logic grant_n_r;
    logic hang_n_r;
    logic stall_r;
    logic pins_oe_r;
    logic data_oe_r;
    logic done_r;
    logic byte_hi_r;
    logic [7:0] byte_lo_r;
    logic [eba_pkg::DATA_W-1:0] rdata_r;
    eba_pkg::eba_pins_s pins_r;
    logic [eba_pkg::NUM_CH-1:0] dma_gnt_r;
    logic [eba_pkg::CH_W-1:0] dma_ch_r;
    logic [eba_pkg::NUM_CH-1:0] dma_done_r;
    logic [eba_pkg::ADDR_W-1:0] dma_addr_r;
    logic ext_req;
    logic int_pending;
    eba_pkg::eba_acc_s acc;
    logic [eba_pkg::NUM_CH-1:0] ch_req;
    logic [eba_pkg::NUM_CH-1:0] ch_onehot;
    logic [eba_pkg::CH_W-1:0] ch_index;
    logic [eba_pkg::ADDR_W-1:0] ch_addr [eba_pkg::NUM_CH];
    // read data is taken one cycle after the address and strobes go out
    logic cap_r;
    logic cap_last_r;

    // rstn is the arbiter's own power-on reset; dev_reset_n is the device
    // reset and deliberately does not touch request/grant handling
    assign ext_req = req_sync2_r;
    // internal requests outrank the external one
    assign int_pending = core_acc.valid || periph_acc.valid;
    // core first, then peripheral traffic
    assign acc = core_acc.valid ? core_acc : periph_acc;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_sync1_r <= 1'b0;
            req_sync2_r <= 1'b0;
        end else begin
            req_sync1_r <= !ext_bus_request_n;
            req_sync2_r <= req_sync1_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            eba_pkg::EBA_OWN: begin
                if (ext_req && !exclusive_core) begin
                    state_nxt = eba_pkg::EBA_WAIT;
                end
            end
            eba_pkg::EBA_WAIT: begin
                if (!ext_req || exclusive_core) begin
                    state_nxt = eba_pkg::EBA_OWN;
                end else if (wait_r == 2'(eba_pkg::GRANT_MIN_CYC - 2)
                             && !int_pending
                             && !pair_lock_r) begin
                    state_nxt = eba_pkg::EBA_FLOAT;
                end
            end
            eba_pkg::EBA_FLOAT: begin
                state_nxt = eba_pkg::EBA_GRANTED;
            end
            eba_pkg::EBA_GRANTED: begin
                if (!ext_req) begin
                    state_nxt = eba_pkg::EBA_OWN;
                end
            end
            default: begin
                state_nxt = eba_pkg::EBA_OWN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= eba_pkg::EBA_OWN;
            wait_r <= eba_pkg::GNT_WAIT_INIT;
        end else begin
            state_r <= state_nxt;
            if (state_r != eba_pkg::EBA_WAIT) begin
                wait_r <= eba_pkg::GNT_WAIT_INIT;
            end else if (wait_r != 2'(eba_pkg::GRANT_MIN_CYC - 2)) begin
                wait_r <= wait_r + 2'h1;
            end
        end
    end

    // pair lock: first read of a two-read instruction blocks a grant
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pair_lock_r <= 1'b0;
        end else if (acc.valid) begin
            // a pair locks when its first access is a read; write then read may be split
            pair_lock_r <= acc.pair_first && !acc.write;
        end
    end

    // grant output and driver enables
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            grant_n_r <= 1'b1;
            pins_oe_r <= 1'b0;
        end else begin
            // drivers float one cycle before the grant goes low
            pins_oe_r <= (state_nxt == eba_pkg::EBA_OWN)
                         || (state_nxt == eba_pkg::EBA_WAIT);
            grant_n_r <= !(state_nxt == eba_pkg::EBA_GRANTED);
        end
    end

    // stall and grant-hang
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stall_r <= 1'b0;
            hang_n_r <= 1'b1;
        end else begin
            stall_r <= core_acc.valid
                       && (state_nxt == eba_pkg::EBA_FLOAT
                           || state_nxt == eba_pkg::EBA_GRANTED);
            hang_n_r <= !(acc.valid
                          && (state_nxt == eba_pkg::EBA_FLOAT
                              || state_nxt == eba_pkg::EBA_GRANTED));
        end
    end

    // external access: one cycle per 16-bit word, two bytes on 8-bit bus
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_r <= '{default: '1};
            data_oe_r <= 1'b0;
            done_r <= 1'b0;
            byte_hi_r <= 1'b0;
            byte_lo_r <= 8'h00;
            rdata_r <= '0;
            cap_r <= 1'b0;
            cap_last_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            cap_r <= 1'b0;
            data_oe_r <= 1'b0;
            pins_r.rd_n <= 1'b1;
            pins_r.wr_n <= 1'b1;
            pins_r.bank_select_n <= '1;
            pins_r.boot_space_select_n <= 1'b1;
            pins_r.io_space_select_n <= 1'b1;
            if (cap_r) begin
                // memory answers while the access stands on the pins
                if (!cap_last_r) begin
                    byte_lo_r <= data_in[7:0];
                end else begin
                    done_r <= 1'b1;
                    rdata_r <= bus_8bit ? {data_in[7:0], byte_lo_r}
                                        : data_in;
                end
            end else if (acc.valid && state_r != eba_pkg::EBA_FLOAT
                && state_r != eba_pkg::EBA_GRANTED && !done_r) begin
                cap_r <= 1'b1;
                pins_r.addr <= {acc.addr[eba_pkg::ADDR_W-2:0],
                                byte_hi_r & bus_8bit};
                pins_r.bank_select_n <= ~acc.bank_sel;
                pins_r.boot_space_select_n <= !acc.boot_sel;
                pins_r.io_space_select_n <= !acc.io_sel;
                pins_r.rd_n <= acc.write;
                pins_r.wr_n <= !acc.write;
                data_oe_r <= acc.write;
                pins_r.data <= (bus_8bit && byte_hi_r)
                               ? {8'h00, acc.wdata[15:8]}
                               : acc.wdata;
                if (bus_8bit && !byte_hi_r) begin
                    byte_hi_r <= 1'b1;
                    cap_last_r <= 1'b0;
                end else begin
                    byte_hi_r <= 1'b0;
                    cap_last_r <= 1'b1;
                end
            end
        end
    end

    // dma: own channel per peripheral, cycle-stolen internal bus
    genvar g;
    generate
        for (g = 0; g < eba_pkg::NUM_CH; g++) begin : g_ch
            eba_dma_chan u_chan (
                .clk(clk),
                .rstn(rstn),
                .start(dma_start[g]),
                .desc(dma_desc),
                .next_desc(dma_next_desc),
                .granted(dma_gnt_r[g]),
                .req(ch_req[g]),
                .addr(ch_addr[g]),
                .done(dma_done_r[g])
            );
        end
    endgenerate

    eba_dma_prio u_prio (
        .req(ch_req & ~dma_gnt_r),
        .onehot(ch_onehot),
        .index(ch_index)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dma_gnt_r <= eba_pkg::REQ_NONE;
            dma_ch_r <= eba_pkg::CH_NONE;
            dma_addr_r <= '0;
        end else begin
            // steals a cycle each time, independent of external grant
            dma_gnt_r <= ch_onehot;
            dma_ch_r <= ch_index;
            if (ch_index != eba_pkg::CH_NONE) begin
                dma_addr_r <= ch_addr[ch_index];
            end
        end
    end

    assign ext_bus_grant_n = grant_n_r;
    assign grant_hang_n = hang_n_r;
    assign core_stall = stall_r;
    assign acc_done = done_r;
    assign rdata = rdata_r;
    assign pins_out = pins_r;
    assign pins_oe = pins_oe_r;
    assign data_oe = data_oe_r;
    assign dma_grant = dma_gnt_r;
    assign dma_grant_ch = dma_ch_r;
    assign dma_done = dma_done_r;
    assign dma_addr = dma_addr_r;
endmodule : eba_arbiter

// *** src/eba_pkg.sv ***
// shared constants and carriers for the external port and dma bus arbiter
// assumes a single 250 MHz peripheral clock and no software registers
package eba_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int BANK_W = 4;
    localparam int NUM_CH = 5;
    localparam int CH_W = 3;
    localparam int CNT_W = 16;
    // least request-to-grant spacing, in peripheral clocks
    localparam int GRANT_MIN_CYC = 3;
    localparam logic [1:0] GNT_WAIT_INIT = 2'h0;
    localparam logic [CH_W-1:0] CH_NONE = 3'h7;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [NUM_CH-1:0] REQ_NONE = 5'h00;

    typedef enum logic [2:0] {
        EBA_OWN,
        EBA_WAIT,
        EBA_FLOAT,
        EBA_GRANTED
    } eba_arb_e;

    // one core or peripheral access presented to the external port
    typedef struct packed {
        logic valid;
        logic write;
        logic pair_first;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [BANK_W-1:0] bank_sel;
        logic boot_sel;
        logic io_sel;
    } eba_acc_s;

    // external pin group driven by the device
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BANK_W-1:0] bank_select_n;
        logic boot_space_select_n;
        logic io_space_select_n;
        logic rd_n;
        logic wr_n;
    } eba_pins_s;

    // dma descriptor: start address, word count, chain link
    typedef struct packed {
        logic [ADDR_W-1:0] start;
        logic [CNT_W-1:0] count;
        logic link_valid;
    } eba_desc_s;
endpackage : eba_pkg

// *** src/eba_dma_prio.sv ***
// fixed-priority selector of the shared dma bus
// assumes each channel holds its request until granted
`timescale 1ns/10ps
module eba_dma_prio (
    input wire logic [eba_pkg::NUM_CH-1:0] req,
    output logic [eba_pkg::NUM_CH-1:0] onehot,
    output logic [eba_pkg::CH_W-1:0] index
);
    // lowest index wins: 0 serial rx .. 4 memory dma
    function automatic logic [eba_pkg::CH_W-1:0] first_set(
        input logic [eba_pkg::NUM_CH-1:0] r
    );
        logic [eba_pkg::CH_W-1:0] k;
        k = eba_pkg::CH_NONE;
        for (int i = eba_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (r[i]) begin
                k = eba_pkg::CH_W'(i);
            end
        end
        return k;
    endfunction : first_set

    always_comb begin
        index = first_set(req);
        onehot = eba_pkg::REQ_NONE;
        if (index != eba_pkg::CH_NONE) begin
            onehot[index] = 1'b1;
        end
    end
endmodule : eba_dma_prio

// *** src/eba_dma_chan.sv ***
// one dma channel with descriptor chaining
// assumes the owner loads a first descriptor and supplies the next one
`timescale 1ns/10ps
module eba_dma_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire eba_pkg::eba_desc_s desc,
    input wire eba_pkg::eba_desc_s next_desc,
    input wire logic granted,
    output logic req,
    output logic [eba_pkg::ADDR_W-1:0] addr,
    output logic done
);
    logic [eba_pkg::CNT_W-1:0] cnt_r;
    logic [eba_pkg::ADDR_W-1:0] addr_r;
    logic link_r;
    logic done_r;

    assign req = (cnt_r != eba_pkg::CNT_ZERO);
    assign addr = addr_r;
    assign done = done_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= eba_pkg::CNT_ZERO;
            addr_r <= '0;
            link_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start && cnt_r == eba_pkg::CNT_ZERO) begin
                cnt_r <= desc.count;
                addr_r <= desc.start;
                link_r <= desc.link_valid;
            end else if (granted && req) begin
                if (cnt_r == eba_pkg::CNT_ONE) begin
                    done_r <= 1'b1;
                    if (link_r) begin
                        // chained: load the next sequence at once
                        cnt_r <= next_desc.count;
                        addr_r <= next_desc.start;
                        link_r <= next_desc.link_valid;
                    end else begin
                        cnt_r <= eba_pkg::CNT_ZERO;
                    end
                end else begin
                    cnt_r <= cnt_r - eba_pkg::CNT_ONE;
                    addr_r <= addr_r + eba_pkg::ADDR_W'(1);
                end
            end
        end
    end
endmodule : eba_dma_chan

// *** sim/eba_ext_master.sv ***
// external bus master model: requests, holds the bus, releases
// started by the bench through go, sampled on the rising edge
`timescale 1ns/10ps
module eba_ext_master (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] hold_cyc,
    input wire logic ext_bus_grant_n,
    output logic ext_bus_request_n,
    output logic [7:0] wait_cyc,
    output logic busy
);
    initial begin
        ext_bus_request_n = 1'b1;
        wait_cyc = 8'h00;
        busy = 1'b0;
    end
    always begin
        @(posedge clk);
        if (go) begin
            busy = 1'b1;
            @(negedge clk);
            wait_cyc = 8'h00;
            ext_bus_request_n = 1'b0;
            while (ext_bus_grant_n !== 1'b0 && wait_cyc != 8'hFF) begin
                @(negedge clk);
                wait_cyc = wait_cyc + 8'h01;
            end
            repeat (hold_cyc) @(negedge clk);
            ext_bus_request_n = 1'b1;
            @(negedge clk);
            busy = 1'b0;
        end
    end
endmodule : eba_ext_master

// *** sim/eba_arbiter_asserts.sv ***
// port-level checks of the external port and dma arbiter
// bound to every eba_arbiter instance
`timescale 1ns/10ps
module eba_arbiter_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ext_bus_request_n,
    input wire logic exclusive_core,
    input wire eba_pkg::eba_acc_s core_acc,
    input wire logic acc_done,
    input wire logic ext_bus_grant_n,
    input wire logic grant_hang_n,
    input wire logic core_stall,
    input wire logic pins_oe,
    input wire logic data_oe,
    input wire logic [eba_pkg::NUM_CH-1:0] dma_grant,
    input wire logic [eba_pkg::CH_W-1:0] dma_grant_ch
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_grant;
        $fell(ext_bus_grant_n);
    endsequence
    sequence s_away_acc;
        (core_acc.valid && !ext_bus_grant_n) [*2];
    endsequence
    sequence s_pair_end;
        acc_done && core_acc.pair_first && !core_acc.write;
    endsequence
    grant_min_wait_a: assert property (s_grant |-> !$past(ext_bus_request_n, 3))
        else $error("grant too soon after request");
    float_before_a: assert property (s_grant |-> !$past(pins_oe) && !pins_oe)
        else $error("drivers not floated before grant");
    grant_float_a: assert property (!ext_bus_grant_n |-> !pins_oe && !data_oe)
        else $error("drivers on while granted");
    excl_block_a: assert property (s_grant |-> !$past(exclusive_core))
        else $error("grant in exclusive mode");
    stall_away_a: assert property (s_away_acc |-> core_stall && !grant_hang_n)
        else $error("no stall or hang while bus away");
    hang_idle_a: assert property (ext_bus_grant_n [*3] |-> grant_hang_n)
        else $error("hang without granted bus");
    release_a: assert property ($rose(ext_bus_request_n) |-> ##[1:4] ext_bus_grant_n)
        else $error("grant not released");
    hold_grant_a: assert property (!ext_bus_grant_n && !ext_bus_request_n |=> !ext_bus_grant_n)
        else $error("grant dropped while requested");
    pair_lock_a: assert property (s_pair_end |=> ext_bus_grant_n)
        else $error("grant inside read pair");
    dma_one_a: assert property ($onehot0(dma_grant))
        else $error("several dma grants");
    dma_index_a: assert property (dma_grant != 5'h00 |-> dma_grant == (5'h01 << dma_grant_ch))
        else $error("dma index mismatch");
    dma_spread_a: assert property (dma_grant != 5'h00 |=> (dma_grant & $past(dma_grant)) == 5'h00)
        else $error("dma channel granted twice running");
endmodule : eba_arbiter_chk

bind eba_arbiter eba_arbiter_chk u_chk (.clk, .rstn, .ext_bus_request_n,
    .exclusive_core, .core_acc, .acc_done, .ext_bus_grant_n, .grant_hang_n,
    .core_stall, .pins_oe, .data_oe, .dma_grant, .dma_grant_ch);

// *** sim/testbench.sv ***
// self-checking bench for the external port and dma arbiter
// one clock; the external master model sits in its own file
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic dev_reset_n = 1'b1;
    logic exclusive_core = 1'b0;
    logic bus_8bit = 1'b0;
    logic go = 1'b0;
    eba_pkg::eba_acc_s core_acc = '0;
    eba_pkg::eba_acc_s periph_acc = '0;
    eba_pkg::eba_desc_s dma_desc = '0;
    eba_pkg::eba_desc_s dma_next_desc = '0;
    eba_pkg::eba_pins_s pins_out;
    logic [4:0] dma_start = 5'h00;
    logic [4:0] dma_grant, dma_done;
    logic [2:0] dma_grant_ch;
    logic [19:0] dma_addr;
    logic [15:0] data_in, rdata, rd;
    logic [7:0] hold_cyc = 8'h00;
    logic [7:0] wait_cyc;
    logic ext_bus_request_n, ext_bus_grant_n, grant_hang_n, core_stall;
    logic acc_done, pins_oe, data_oe, mbusy;
    int miscompares = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    // memory answer: odd byte address gives the upper pattern
    assign data_in = pins_out.addr[0] ? 16'h12AB : 16'h34CD;
    eba_arbiter dut (.clk, .rstn, .dev_reset_n, .ext_bus_request_n,
        .exclusive_core, .bus_8bit, .core_acc, .periph_acc, .data_in,
        .dma_start, .dma_desc, .dma_next_desc, .ext_bus_grant_n,
        .grant_hang_n, .core_stall, .acc_done, .rdata, .pins_out, .pins_oe,
        .data_oe, .dma_grant, .dma_grant_ch, .dma_done, .dma_addr);
    eba_ext_master u_master (.clk, .go, .hold_cyc, .ext_bus_grant_n,
        .ext_bus_request_n, .wait_cyc, .busy(mbusy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string m);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic close_out;
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wait_grant;
        for (int k = 0; k < 300 && ext_bus_grant_n !== 1'b0; k++)
            @(negedge clk);
    endtask : wait_grant
    task automatic ext_req(input logic [7:0] h);
        hold_cyc = h;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask : ext_req
    task automatic ext_done;
        for (int k = 0; k < 400 && mbusy !== 1'b0; k++)
            @(negedge clk);
    endtask : ext_done
    task automatic core_go(input logic pf, input logic [19:0] a);
        core_acc = '0;
        core_acc.valid = 1'b1;
        core_acc.pair_first = pf;
        core_acc.addr = a;
        core_acc.bank_sel = 4'h1;
    endtask : core_go
    task automatic core_end;
        for (int k = 0; k < 300 && acc_done !== 1'b1; k++)
            @(negedge clk);
        rd = rdata;
        core_acc.valid = 1'b0;
    endtask : core_end
    task automatic t_grant;
        dev_reset_n = 1'b0;
        ext_req(8'h08);
        wait_grant();
        cyc(1);
        chk(wait_cyc >= eba_pkg::GRANT_MIN_CYC, 1'b1, "early grant");
        chk(ext_bus_grant_n, 1'b0, "grant in device reset");
        chk({pins_oe, data_oe}, 2'h0, "drivers on at grant");
        dev_reset_n = 1'b1;
        ext_done();
        cyc(4);
        chk({ext_bus_grant_n, pins_oe}, 2'h3, "bus not returned");
    endtask : t_grant
    task automatic t_busy;
        periph_acc.valid = 1'b1;
        periph_acc.bank_sel = 4'h2;
        ext_req(8'h02);
        cyc(20);
        chk(ext_bus_grant_n, 1'b1, "grant over access");
        for (int k = 0; k < 300 && acc_done !== 1'b1; k++)
            @(negedge clk);
        periph_acc.valid = 1'b0;
        ext_done();
        chk(wait_cyc > 8'h13, 1'b1, "refused request granted");
    endtask : t_busy
    task automatic t_excl;
        exclusive_core = 1'b1;
        ext_req(8'h02);
        cyc(20);
        chk(ext_bus_grant_n, 1'b1, "grant in exclusive mode");
        exclusive_core = 1'b0;
        ext_done();
        chk(wait_cyc > 8'h13, 1'b1, "exclusive wait short");
    endtask : t_excl
    task automatic t_stall;
        ext_req(8'h20);
        wait_grant();
        core_go(1'b0, 20'h00040);
        cyc(4);
        chk({core_stall, grant_hang_n}, 2'h2, "no stall or hang");
        chk({acc_done, pins_oe}, 2'h0, "access on granted bus");
        core_end();
        chk({acc_done, ext_bus_grant_n}, 2'h3, "stalled access lost");
        cyc(3);
        chk({core_stall, grant_hang_n}, 2'h1, "stall after resume");
        ext_done();
    endtask : t_stall
    task automatic t_pair;
        core_go(1'b1, 20'h00010);
        ext_req(8'h02);
        core_end();
        for (int k = 0; k < 4; k++) begin
            chk(ext_bus_grant_n, 1'b1, "grant inside read pair");
            @(negedge clk);
        end
        core_go(1'b0, 20'h00011);
        core_end();
        chk(rd, 16'h34CD, "16-bit read data");
        ext_done();
        chk(wait_cyc > 8'h04, 1'b1, "pair not protected");
    endtask : t_pair
    task automatic t_bytes;
        bus_8bit = 1'b1;
        core_go(1'b0, 20'h00020);
        core_end();
        chk(rd, 16'hABCD, "byte packing");
        bus_8bit = 1'b0;
    endtask : t_bytes
    task automatic t_dma;
        logic [2:0] q[$];
        logic [4:0] d;
        d = 5'h00;
        dma_desc = '{start: 20'h00100, count: 16'h0001, link_valid: 1'b0};
        dma_start = 5'h1F;
        @(negedge clk);
        dma_start = 5'h00;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            d = d | dma_done;
            if (dma_grant !== 5'h00)
                q.push_back(dma_grant_ch);
        end
        chk(q.size(), 5, "dma grant count");
        chk(d, 5'h1F, "dma channels done");
        for (int k = 0; k < q.size(); k++)
            chk(q[k], k, "dma priority order");
    endtask : t_dma
    task automatic t_chain;
        logic [19:0] a[$];
        dma_desc = '{start: 20'h00100, count: 16'h0001, link_valid: 1'b1};
        dma_next_desc = '{start: 20'h00200, count: 16'h0002,
                          link_valid: 1'b0};
        dma_start = 5'h04;
        @(negedge clk);
        dma_start = 5'h00;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            if (dma_grant !== 5'h00)
                a.push_back(dma_addr);
        end
        chk(a.size(), 3, "chained word count");
        chk(a[0], 20'h00100, "first descriptor address");
        chk(a[1], 20'h00200, "chained descriptor address");
    endtask : t_chain
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_grant();
        t_busy();
        t_excl();
        t_stall();
        t_pair();
        t_bytes();
        t_dma();
        t_chain();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out();
    end
endmodule : testbench
